/* upcount_watchdog_timer.sv */
`timescale 1ns/1ps

module upcount_watchdog_timer
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic [31:0] hrdata,
  output      logic        hreadyout,
  output      logic        hresp,
  // Standby state from the power controller
  input  wire logic        halt_mode,
  input  wire logic        idle_mode,
  input  wire logic        stop_mode,
  // Watchdog events
  output      logic        nmi_req,
  output      logic        sys_reset_req
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                              wr_pend_r;
  logic                              wr_pend_nxt;
  logic [wdt_pkg::ADDR_W-1:0]        wr_addr_r;
  logic [wdt_pkg::ADDR_W-1:0]        wr_addr_nxt;
  logic [31:0]                       hrdata_r;
  logic [31:0]                       hrdata_nxt;
  wdt_pkg::mode_t                    mode_r;
  wdt_pkg::mode_t                    mode_nxt;
  logic [wdt_pkg::CNT_W-1:0]         cnt_r;
  logic [wdt_pkg::CNT_W-1:0]         cnt_nxt;
  wdt_pkg::wdt_evt_t                 evt_r;
  wdt_pkg::wdt_evt_t                 evt_nxt;
  logic                              seen_r;
  logic                              seen_nxt;
  logic                              addr_phase;
  logic                              mode_wr;
  logic                              restart_wr;
  logic                              key_ok;
  logic                              counting;
  logic                              tick;
  logic                              overflow;
  logic                              fire;
  logic                              restart;
  logic [wdt_pkg::MODE_W-1:0]        wr_byte;

  // Aligned word select from a byte address
  function automatic logic hit
  (
    input logic [wdt_pkg::ADDR_W-1:0] a,
    input logic [wdt_pkg::ADDR_W-1:0] reg_addr
  );
    hit = (a == reg_addr);
  endfunction : hit

  // ****************************************************************
  // Bus slave
  // ****************************************************************

  // Zero wait states, always OKAY
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel && hready &&
                      (htrans == wdt_pkg::HTRANS_NONSEQ ||
                       htrans == wdt_pkg::HTRANS_SEQ);
  assign wr_byte    = hwdata[wdt_pkg::MODE_LSB +: wdt_pkg::MODE_W];

  // Capture write address; read data registered in address phase
  always_comb
  begin
    wr_pend_nxt = addr_phase && hwrite;
    wr_addr_nxt = wr_addr_r;
    hrdata_nxt  = hrdata_r;
    if (addr_phase)
    begin
      wr_addr_nxt = haddr[wdt_pkg::ADDR_W-1:0];
    end
    if (addr_phase && !hwrite)
    begin
      // Unmapped and restart words read as zero
      hrdata_nxt = '0;
      if (hit(haddr[wdt_pkg::ADDR_W-1:0], wdt_pkg::MODE_ADDR))
      begin
        hrdata_nxt[wdt_pkg::MODE_LSB +: wdt_pkg::MODE_W] = mode_r;
      end
      else if (hit(haddr[wdt_pkg::ADDR_W-1:0], wdt_pkg::STATUS_ADDR))
      begin
        hrdata_nxt[wdt_pkg::CNT_W-1:0]        = cnt_r;
        hrdata_nxt[wdt_pkg::STAT_EVT_BIT]     = seen_r;
      end
    end
  end

  // Bus registers
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata_r  <= '0;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r  <= hrdata_nxt;
    end
  end

  assign hrdata     = hrdata_r;
  assign mode_wr    = wr_pend_r && hit(wr_addr_r, wdt_pkg::MODE_ADDR);
  assign restart_wr = wr_pend_r && hit(wr_addr_r, wdt_pkg::RESTART_ADDR);
  assign key_ok     = (wr_byte == wdt_pkg::RESTART_KEY);

  // ****************************************************************
  // Mode register
  // ****************************************************************

  // Writing zero drops run, so the timer sits unused
  always_comb
  begin
    mode_nxt = mode_r;
    if (mode_wr)
    begin
      mode_nxt        = wdt_pkg::mode_t'(wr_byte);
      mode_nxt.pad_hi = '0;
    end
  end

  // Comes out of reset running, so an unused timer must be turned off
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_r <= wdt_pkg::mode_t'(wdt_pkg::MODE_RESET);
    end
    else
    begin
      mode_r <= mode_nxt;
    end
  end

  // ****************************************************************
  // Count clock
  // ****************************************************************

  // Halt keeps the clock going; idle and stop freeze it
  assign counting = mode_r.run && !idle_mode && !stop_mode;
  assign restart  = restart_wr && key_ok;

  wdt_prescaler wdt_prescaler_inst
  (
    .clock (clock),
    .rst_b (rst_b),
    .run   (counting),
    .clear (restart || mode_wr),
    .sel   (mode_r.sel),
    .tick  (tick)
  );

  // ****************************************************************
  // Counter and events
  // ****************************************************************
  assign overflow = counting && tick && (cnt_r == wdt_pkg::CNT_MAX);
  // A wrong key only counts while the timer is in use
  assign fire     = mode_r.run &&
                    (overflow || (restart_wr && !key_ok));

  // Up-count, cleared by the key; wraps to zero at overflow
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (restart || mode_wr)
    begin
      cnt_nxt = wdt_pkg::CNT_ZERO;
    end
    else if (counting && tick)
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  // One-cycle event on the selected output; sticky seen flag
  always_comb
  begin
    evt_nxt     = '0;
    seen_nxt    = seen_r;
    if (restart)
    begin
      seen_nxt = 1'b0;
    end
    if (fire)
    begin
      seen_nxt    = 1'b1; // Set wins over the key clear
      evt_nxt.rst = mode_r.resp_reset;
      evt_nxt.nmi = !mode_r.resp_reset;
    end
  end

  // Counter and event registers
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r  <= wdt_pkg::CNT_ZERO;
      evt_r  <= '0;
      seen_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      evt_r  <= evt_nxt;
      seen_r <= seen_nxt;
    end
  end

  assign nmi_req       = evt_r.nmi;
  assign sys_reset_req = evt_r.rst;

endmodule : upcount_watchdog_timer

/* upcount_watchdog_timer_test.sv */
`timescale 1ns/1ps

// ****************************************************************
// Watchdog testbench
// ****************************************************************
module upcount_watchdog_timer_test;
  logic        clock, rst_b, hsel, hwrite, hready, hreadyout, hresp;
  logic        halt_mode, idle_mode, stop_mode, nmi_req, sys_reset_req;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, s1;
  int          num_errors = 0, n_tests = 0, cycles = 0, n_nmi = 0;
  int          n_rst = 0;

  assign hready = hreadyout;

  upcount_watchdog_timer upcount_watchdog_timer_inst
  (
    .clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .halt_mode,
    .idle_mode, .stop_mode, .nmi_req, .sys_reset_req
  );

  // 100 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Pulse tally; the guard cuts a hung bus wait short
  always @(posedge clock)
  begin
    cycles++;
    if (nmi_req === 1'b1) n_nmi++;
    if (sys_reset_req === 1'b1) n_rst++;
    if (cycles == 30000)
    begin
      num_errors++;
      results();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // One single transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    hsel   <= 1'b1;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    htrans <= wdt_pkg::HTRANS_NONSEQ;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask : bus

  // Two status reads exactly four count periods apart, so phase
  // of the prescaler cannot skew the difference
  task automatic delta(input int lg, input logic [31:0] exp);
    bus(1'b0, wdt_pkg::STATUS_ADDR, 32'h0);
    s1 = rd;
    repeat ((4 << lg) - 3) @(posedge clock);
    bus(1'b0, wdt_pkg::STATUS_ADDR, 32'h0);
    cmp({16'h0000, rd[15:0] - s1[15:0]}, exp);
  endtask : delta

  task automatic t_reset;
    bus(1'b0, wdt_pkg::MODE_ADDR, 32'h0);
    cmp(rd, {24'h000000, wdt_pkg::MODE_RESET});
    bus(1'b0, wdt_pkg::RESTART_ADDR, 32'h0);
    cmp(rd, 32'h0);
    bus(1'b0, 8'h0C, 32'h0);
    cmp(rd, 32'h0);
    cmp({31'h0, hresp}, 32'h0);
    cmp({30'h0, nmi_req, sys_reset_req}, 32'h0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_periods;
    for (int s = 0; s < 8; s++)
    begin
      bus(1'b1, wdt_pkg::MODE_ADDR, 32'h80 | s);
      delta(s + 3, 32'h4);
    end
    $display("t_periods done");
  endtask : t_periods

  task automatic t_standby;
    bus(1'b1, wdt_pkg::MODE_ADDR, 32'h80);
    idle_mode <= 1'b1;
    delta(3, 32'h0);
    idle_mode <= 1'b0;
    stop_mode <= 1'b1;
    delta(3, 32'h0);
    stop_mode <= 1'b0;
    halt_mode <= 1'b1;
    delta(3, 32'h4);
    halt_mode <= 1'b0;
    $display("t_standby done");
  endtask : t_standby

  // Wrong keys in both responses, then the right key
  task automatic t_events;
    bus(1'b1, wdt_pkg::MODE_ADDR, 32'h80);
    bus(1'b1, wdt_pkg::RESTART_ADDR, 32'h55);
    bus(1'b1, wdt_pkg::MODE_ADDR, 32'h88);
    bus(1'b1, wdt_pkg::RESTART_ADDR, 32'hFF);
    bus(1'b0, wdt_pkg::STATUS_ADDR, 32'h0);
    cmp({31'h0, rd[16]}, 32'h1);
    cmp(n_nmi, 32'h1);
    cmp(n_rst, 32'h1);
    bus(1'b1, wdt_pkg::RESTART_ADDR, {24'h0, wdt_pkg::RESTART_KEY});
    bus(1'b0, wdt_pkg::STATUS_ADDR, 32'h0);
    cmp(rd, 32'h0);
    cmp(n_nmi + n_rst, 32'h2);
    $display("t_events done");
  endtask : t_events

  // Mode of zero leaves the timer idle, even for a bad key
  task automatic t_unused;
    bus(1'b1, wdt_pkg::MODE_ADDR, {24'h0, wdt_pkg::MODE_UNUSED});
    bus(1'b1, wdt_pkg::RESTART_ADDR, 32'h12);
    delta(3, 32'h0);
    cmp(n_nmi + n_rst, 32'h2);
    $display("t_unused done");
  endtask : t_unused

  task automatic results;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // Reset for eight cycles, then the scenarios
  initial
  begin
    rst_b     = 1'b0;
    hsel      = 1'b0;
    hwrite    = 1'b0;
    htrans    = 2'h0;
    haddr     = 32'h0;
    hwdata    = 32'h0;
    halt_mode = 1'b0;
    idle_mode = 1'b0;
    stop_mode = 1'b0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    t_periods();
    t_standby();
    t_events();
    t_unused();
    results();
  end
endmodule : upcount_watchdog_timer_test

/* wdt_checker.sv */
`timescale 1ns/1ps

// ****************************************************************
// Watchdog port checker
// ****************************************************************
module wdt_checker
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  // Standby and events
  input  wire logic        idle_mode,
  input  wire logic        stop_mode,
  input  wire logic        nmi_req,
  input  wire logic        sys_reset_req
);
  logic ap, bad, wm_r, wk_r, run_r, rsp_r;
  logic wm_nxt, wk_nxt, run_nxt, rsp_nxt;

  // Write phases and a mode shadow; data trails address by one
  always_comb
  begin
    ap      = hsel && hready && htrans[1] && hwrite;
    wm_nxt  = ap && (haddr[7:0] == wdt_pkg::MODE_ADDR);
    wk_nxt  = ap && (haddr[7:0] == wdt_pkg::RESTART_ADDR);
    run_nxt = wm_r ? hwdata[7] : run_r;
    rsp_nxt = wm_r ? hwdata[3] : rsp_r;
    bad     = wk_r && run_r && (hwdata[7:0] != wdt_pkg::RESTART_KEY);
  end

  // Shadow starts as the reset mode value, run and response bits
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wm_r  <= 1'b0;
      wk_r  <= 1'b0;
      run_r <= wdt_pkg::MODE_RESET[7];
      rsp_r <= wdt_pkg::MODE_RESET[3];
    end
    else
    begin
      wm_r  <= wm_nxt;
      wk_r  <= wk_nxt;
      run_r <= run_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  evt_excl_a: assert property (
    !(nmi_req && sys_reset_req)) else $error("two events at once");
  nmi_kind_a: assert property (
    nmi_req |-> !$past(rsp_r)) else $error("nmi in reset response");
  rst_kind_a: assert property (
    sys_reset_req |-> $past(rsp_r)) else $error("reset in nmi response");
  bad_key_a: assert property (
    bad |=> (rsp_r ? sys_reset_req : nmi_req)) else $error("no event");
  good_key_a: assert property (
    wk_r && (hwdata[7:0] == wdt_pkg::RESTART_KEY)
    |=> (!nmi_req && !sys_reset_req) ##1
        ($past(bad) || (!nmi_req && !sys_reset_req)))
    else $error("key fired");
  evt_pulse_a: assert property (
    (nmi_req || sys_reset_req) && !bad |=> !nmi_req && !sys_reset_req)
    else $error("event longer than one cycle");
  frozen_a: assert property (
    (idle_mode || stop_mode) && !bad |=> !nmi_req && !sys_reset_req)
    else $error("event while frozen");

  nmi_seen_c: cover property (nmi_req);
  rst_seen_c: cover property (sys_reset_req);
  idle_held_c: cover property (idle_mode ##1 idle_mode);
endmodule : wdt_checker

bind upcount_watchdog_timer wdt_checker wdt_checker_inst
(
  .clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .idle_mode, .stop_mode, .nmi_req, .sys_reset_req
);

/* wdt_pkg.sv */
package wdt_pkg;

  // ****************************************************************
  // Bus map, byte addresses of the 32-bit words
  // ****************************************************************
  localparam logic [7:0]  MODE_ADDR    = 8'h00;
  localparam logic [7:0]  RESTART_ADDR = 8'h04;
  localparam logic [7:0]  STATUS_ADDR  = 8'h08;
  localparam int          ADDR_W       = 8;

  // ****************************************************************
  // Mode register fields and values
  // ****************************************************************
  localparam int          SEL_W        = 3;
  localparam int          MODE_LSB     = 0;
  localparam int          MODE_W       = 8;
  localparam logic [7:0]  MODE_RESET   = 8'h87;
  localparam logic [7:0]  MODE_UNUSED  = 8'h00;
  localparam logic [7:0]  RESTART_KEY  = 8'hAC;

  // Mode register: run in bit 7, response in bit 3, period in 2:0
  typedef struct packed {
    logic             run;
    logic [2:0]       pad_hi;
    logic             resp_reset;
    logic [SEL_W-1:0] sel;
  } mode_t;

  // ****************************************************************
  // Counter and prescaler
  // ****************************************************************
  localparam int          CNT_W        = 16;
  localparam logic [15:0] CNT_MAX      = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam int          PRE_W        = 10;
  // Shortest period 2^19 clocks over 2^16 counts gives 2^3
  localparam int          PRE_BASE_LOG = 3;
  localparam int          STAT_EVT_BIT = 16;

  // Event delivered to the system
  typedef struct packed {
    logic nmi;
    logic rst;
  } wdt_evt_t;

  // AHB transfer types
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

endpackage : wdt_pkg

/* wdt_prescaler.sv */
`timescale 1ns/1ps

// Count clock enable: one pulse every 2^(sel+3) clocks
module wdt_prescaler
(
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  // Control
  input  wire logic                     run,
  input  wire logic                     clear,
  input  wire logic [wdt_pkg::SEL_W-1:0] sel,
  // Count clock enable
  output      logic                     tick
);

  logic [wdt_pkg::PRE_W-1:0] pre_r;
  logic [wdt_pkg::PRE_W-1:0] pre_nxt;
  logic                      tick_r;
  logic                      tick_nxt;

  // Terminal count for a period selection
  function automatic logic [wdt_pkg::PRE_W-1:0] pre_limit
  (
    input logic [wdt_pkg::SEL_W-1:0] s
  );
    logic [wdt_pkg::PRE_W:0] one_hot;
    logic [wdt_pkg::PRE_W:0] limit_full;
    one_hot = '0;
    one_hot[int'(s) + wdt_pkg::PRE_BASE_LOG] = 1'b1;
    // Widest selection needs the top bit only before the decrement
    limit_full = one_hot - 1'b1;
    pre_limit  = limit_full[wdt_pkg::PRE_W-1:0];
  endfunction : pre_limit

  // ****************************************************************
  // Divider
  // ****************************************************************

  // Clear restarts the whole period, not only the visible counter
  always_comb
  begin
    pre_nxt  = pre_r;
    tick_nxt = 1'b0;
    if (clear)
    begin
      pre_nxt = '0;
    end
    else if (run)
    begin
      if (pre_r >= pre_limit(sel))
      begin
        pre_nxt  = '0;
        tick_nxt = 1'b1;
      end
      else
      begin
        pre_nxt = pre_r + 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pre_r  <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      pre_r  <= pre_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule : wdt_prescaler
